// ### sfmdc_pkg.sv
/*
 * shared constants and types for the squib fire monitor and diagnostic block.
 * assumes a 50 MHz system clock and a 16-bit spi frame on the link side.
 */
package sfmdc_pkg;

	// ********************************************************
	// clock and timing
	// ********************************************************
	localparam int SYS_CLK_MHZ = 50;
	localparam int TICK_NS = 25000;
	localparam int TICK_CYC = (TICK_NS * SYS_CLK_MHZ) / 1000;
	localparam int COMP_NS = 12800;
	localparam int COMP_CYC = (COMP_NS * SYS_CLK_MHZ) / 1000;
	localparam int FILT_NS = 12000;
	localparam int FILT_CYC = (FILT_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int HOLD_UNIT_MS = 128;
	localparam int HOLD_UNIT_CYC = HOLD_UNIT_MS * SYS_CLK_MHZ * 1000;

	// ********************************************************
	// widths and counts
	// ********************************************************
	localparam int NCH = 8;
	localparam int NFEN = 4;
	localparam int FT_W = 7;
	localparam int HOLD_W = 25;
	localparam int PRE_W = 11;
	localparam int COMP_W = 10;
	localparam int FILT_W = 10;
	localparam int WORD_W = 16;
	localparam int BIT_W = 4;

	// ********************************************************
	// reset values and codes
	// ********************************************************
	localparam logic [FT_W-1:0] FT_RST = 7'h00;
	localparam logic [FT_W-1:0] FT_FULL = 7'h7f;
	localparam logic [NCH-1:0] CH_RST = 8'h00;
	localparam logic [NCH-1:0] CH_ALL = 8'hff;
	localparam logic [1:0] HOLD_0MS = 2'h0;
	localparam logic [1:0] HOLD_128MS = 2'h1;
	localparam logic [1:0] HOLD_256MS = 2'h2;
	localparam logic [1:0] HOLD_512MS = 2'h3;

	typedef enum logic [1:0] {
		SFMDC_IDLE = 2'b00,
		SFMDC_LEAK = 2'b01,
		SFMDC_RES = 2'b11
	} sfmdc_diag_e;

	typedef struct packed {
		sfmdc_diag_e mode;
		logic [2:0] chan;
		logic low_pin;
		logic pulldown_select;
		logic offset_cal_select;
	} sfmdc_cmd_s;

	typedef struct packed {
		logic [NCH-1:0] cur_status;
		logic battery_short_flag;
		logic ground_short_flag;
		logic leak_pending;
		logic [4:0] spare;
	} sfmdc_resp_s;

endpackage

// ### sfmdc_top.sv
/*
 * firing-time counters, current status, fire-enable functions and the
 * leakage / resistance diagnostic sequencer of an eight-channel squib device.
 * assumes a command decoder on sys_clk supplies pulses and levels, the
 * spi clock runs only inside frames, and analog pins are driven outside.
 */
// Behaviour
// - seven-bit firing-time counter per channel, 25us steps
// - no counting outside the deployment window
// - count only above 95% target current
// - resume from stored value, saturate at ones
// - clear zeroes only the addressed channel
// - clear ignored while that channel fires
// - power-on or soft reset zeroes all counters
// - status sampled each 25us, latched at cs fall
// - offset compensation strobe every 12.8us
// - fire enable is filtered pin or hold latch
// - four functions gate channel pairs 0-1..6-7
// - pin active after 12us continuous high
// - hold after fall for 0/128/256/512 ms
// - rising pin reloads the hold timer
// - high and low pins tested separately
// - plain leak test: all pulldowns off, bias on pin
// - loop test: pulldown off only on tested channel
// - leak comparators captured at next cs fall
// - resistance test drives currents, enables analog out
// - calibration bit selects amplifier offset output
// - deployment window is both drivers on
// - arm command stops all diagnostics
`timescale 1ns/10ps
module sfmdc_top #(
	parameter int HOLD_UNIT = sfmdc_pkg::HOLD_UNIT_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic soft_reset,
	input wire logic [sfmdc_pkg::NCH-1:0] measure_current_threshold,
	input wire logic [sfmdc_pkg::NCH-1:0] high_drv_on,
	input wire logic [sfmdc_pkg::NCH-1:0] low_drv_on,
	input wire logic [sfmdc_pkg::NCH-1:0] clear_req,
	input wire logic [sfmdc_pkg::NFEN-1:0] fire_enable_pin,
	input wire logic [2*sfmdc_pkg::NFEN-1:0] hold_code,
	input wire logic mos_test,
	input wire logic arm_cmd,
	input wire logic diag_start,
	input wire logic diag_stop,
	input wire sfmdc_pkg::sfmdc_cmd_s diag_cmd,
	input wire logic status_req,
	input wire logic battery_leak_comparator,
	input wire logic ground_leak_comparator,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	output logic [sfmdc_pkg::NCH*sfmdc_pkg::FT_W-1:0] fire_time_r,
	output logic [sfmdc_pkg::NCH-1:0] cur_status_r,
	output logic offset_comp_r,
	output logic [sfmdc_pkg::NFEN-1:0] fire_enable_function_r,
	output logic [sfmdc_pkg::NCH-1:0] drive_allow_r,
	output logic [sfmdc_pkg::NCH-1:0] pulldown_en_r,
	output logic [sfmdc_pkg::NCH-1:0] bias_high_r,
	output logic [sfmdc_pkg::NCH-1:0] bias_low_r,
	output logic [sfmdc_pkg::NCH-1:0] meas_source_current_r,
	output logic [sfmdc_pkg::NCH-1:0] meas_sink_current_r,
	output logic analog_meas_oe_r,
	output logic offset_cal_r,
	output sfmdc_pkg::sfmdc_resp_s resp_r,
	output logic miso_r,
	output logic miso_oe_r
);

	// ********************************************************
	// helpers
	// ********************************************************
	function automatic logic [sfmdc_pkg::HOLD_W-1:0] hold_load(
		input logic [1:0] code
	);
		logic [sfmdc_pkg::HOLD_W-1:0] unit;
		unit = sfmdc_pkg::HOLD_W'(HOLD_UNIT);
		unique case (code)
			sfmdc_pkg::HOLD_0MS: hold_load = '0;
			sfmdc_pkg::HOLD_128MS: hold_load = unit;
			sfmdc_pkg::HOLD_256MS: hold_load = unit << 1;
			sfmdc_pkg::HOLD_512MS: hold_load = unit << 2;
		endcase
	endfunction

	function automatic logic [sfmdc_pkg::NCH-1:0] one_hot(
		input logic [2:0] ch
	);
		one_hot = sfmdc_pkg::NCH'(1) << ch;
	endfunction

	// ********************************************************
	// input synchronisers
	// ********************************************************
	logic [sfmdc_pkg::NCH-1:0] cur_meta_r;
	logic [sfmdc_pkg::NCH-1:0] cur_sync_r;
	logic [sfmdc_pkg::NFEN-1:0] fen_meta_r;
	logic [sfmdc_pkg::NFEN-1:0] fen_sync_r;
	logic [1:0] leak_meta_r;
	logic [1:0] leak_sync_r;
	logic cs_meta_r;
	logic cs_sync_r;
	logic cs_prev_r;
	logic cs_fall;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_meta_r <= '0;
			cur_sync_r <= '0;
			fen_meta_r <= '0;
			fen_sync_r <= '0;
			leak_meta_r <= '0;
			leak_sync_r <= '0;
			cs_meta_r <= 1'b1;
			cs_sync_r <= 1'b1;
			cs_prev_r <= 1'b1;
		end else begin
			cur_meta_r <= measure_current_threshold;
			cur_sync_r <= cur_meta_r;
			fen_meta_r <= fire_enable_pin;
			fen_sync_r <= fen_meta_r;
			leak_meta_r <= {battery_leak_comparator, ground_leak_comparator};
			leak_sync_r <= leak_meta_r;
			cs_meta_r <= spi_cs_n;
			cs_sync_r <= cs_meta_r;
			cs_prev_r <= cs_sync_r;
		end
	end

	assign cs_fall = cs_prev_r & ~cs_sync_r;

	// ********************************************************
	// prescaler and compensation strobe
	// ********************************************************
	logic [sfmdc_pkg::PRE_W-1:0] pre_r;
	logic [sfmdc_pkg::COMP_W-1:0] comp_r;
	logic tick;

	// one prescaler for all channels keeps counts in step
	assign tick = (pre_r == sfmdc_pkg::PRE_W'(sfmdc_pkg::TICK_CYC - 1));

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_r <= '0;
		end else if (tick) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	// free running, spi commands do not touch it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			comp_r <= '0;
			offset_comp_r <= 1'b0;
		end else begin
			offset_comp_r <= (comp_r == sfmdc_pkg::COMP_W'(sfmdc_pkg::COMP_CYC - 1));
			if (comp_r == sfmdc_pkg::COMP_W'(sfmdc_pkg::COMP_CYC - 1)) begin
				comp_r <= '0;
			end else begin
				comp_r <= comp_r + 1'b1;
			end
		end
	end

	// ********************************************************
	// firing-time counters
	// ********************************************************
	logic [sfmdc_pkg::NCH-1:0] window;

	assign window = high_drv_on & low_drv_on;

	generate
		for (genvar c = 0; c < sfmdc_pkg::NCH; c++) begin : g_ft
			logic [sfmdc_pkg::FT_W-1:0] cnt;
			assign cnt = fire_time_r[c*sfmdc_pkg::FT_W +: sfmdc_pkg::FT_W];
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					fire_time_r[c*sfmdc_pkg::FT_W +: sfmdc_pkg::FT_W] <= sfmdc_pkg::FT_RST;
				end else if (soft_reset) begin
					fire_time_r[c*sfmdc_pkg::FT_W +: sfmdc_pkg::FT_W] <= sfmdc_pkg::FT_RST;
				end else if (clear_req[c] && !window[c]) begin
					// clear during firing is dropped, not deferred
					fire_time_r[c*sfmdc_pkg::FT_W +: sfmdc_pkg::FT_W] <= sfmdc_pkg::FT_RST;
				end else if (tick && window[c] && cur_sync_r[c] &&
						cnt != sfmdc_pkg::FT_FULL) begin
					fire_time_r[c*sfmdc_pkg::FT_W +: sfmdc_pkg::FT_W] <= cnt + 1'b1;
				end
			end
		end
	endgenerate

	// ********************************************************
	// current status sampling
	// ********************************************************
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_status_r <= sfmdc_pkg::CH_RST;
		end else if (tick) begin
			cur_status_r <= cur_sync_r;
		end
	end

	// ********************************************************
	// fire-enable functions
	// ********************************************************
	logic [sfmdc_pkg::NFEN-1:0] fen_qual_r;

	generate
		for (genvar f = 0; f < sfmdc_pkg::NFEN; f++) begin : g_fen
			logic [sfmdc_pkg::FILT_W-1:0] filt_r;
			logic [sfmdc_pkg::HOLD_W-1:0] hold_r;
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					filt_r <= '0;
					fen_qual_r[f] <= 1'b0;
				end else if (!fen_sync_r[f]) begin
					filt_r <= '0;
					fen_qual_r[f] <= 1'b0;
				end else if (filt_r == sfmdc_pkg::FILT_W'(sfmdc_pkg::FILT_CYC - 1)) begin
					fen_qual_r[f] <= 1'b1;
				end else begin
					filt_r <= filt_r + 1'b1;
				end
			end
			// hold timer stays loaded while the filtered pin is qualified
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					hold_r <= '0;
				end else if (fen_qual_r[f]) begin
					hold_r <= hold_load(hold_code[2*f +: 2]);
				end else if (hold_r != '0) begin
					hold_r <= hold_r - 1'b1;
				end
			end
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					fire_enable_function_r[f] <= 1'b0;
					drive_allow_r[2*f +: 2] <= 2'h0;
				end else begin
					fire_enable_function_r[f] <= fen_qual_r[f] || (hold_r != '0);
					drive_allow_r[2*f +: 2] <= {2{fen_qual_r[f] || (hold_r != '0) ||
						mos_test}};
				end
			end
		end
	endgenerate

	// ********************************************************
	// diagnostic sequencer
	// ********************************************************
	sfmdc_pkg::sfmdc_diag_e diag_r;
	sfmdc_pkg::sfmdc_diag_e diag_nxt;
	sfmdc_pkg::sfmdc_cmd_s cmd_r;

	always_comb begin
		diag_nxt = diag_r;
		if (arm_cmd || diag_stop) begin
			diag_nxt = sfmdc_pkg::SFMDC_IDLE;
		end else if (diag_start) begin
			diag_nxt = diag_cmd.mode;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			diag_r <= sfmdc_pkg::SFMDC_IDLE;
			cmd_r <= '0;
		end else begin
			diag_r <= diag_nxt;
			if (!arm_cmd && (diag_start || diag_stop)) begin
				cmd_r <= diag_cmd;
			end
		end
	end

	// pin drive follows state one cycle later
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pulldown_en_r <= sfmdc_pkg::CH_RST;
			bias_high_r <= sfmdc_pkg::CH_RST;
			bias_low_r <= sfmdc_pkg::CH_RST;
			meas_source_current_r <= sfmdc_pkg::CH_RST;
			meas_sink_current_r <= sfmdc_pkg::CH_RST;
			analog_meas_oe_r <= 1'b0;
			offset_cal_r <= 1'b0;
		end else begin
			pulldown_en_r <= cmd_r.pulldown_select ? sfmdc_pkg::CH_ALL :
				sfmdc_pkg::CH_RST;
			bias_high_r <= sfmdc_pkg::CH_RST;
			bias_low_r <= sfmdc_pkg::CH_RST;
			meas_source_current_r <= sfmdc_pkg::CH_RST;
			meas_sink_current_r <= sfmdc_pkg::CH_RST;
			analog_meas_oe_r <= 1'b0;
			offset_cal_r <= 1'b0;
			unique case (diag_r)
				sfmdc_pkg::SFMDC_IDLE: begin
				end
				sfmdc_pkg::SFMDC_LEAK: begin
					// one pin at a time, so a low-ohm squib cannot mask it
					if (cmd_r.low_pin) begin
						bias_low_r <= one_hot(cmd_r.chan);
					end else begin
						bias_high_r <= one_hot(cmd_r.chan);
					end
					if (cmd_r.pulldown_select) begin
						pulldown_en_r <= ~one_hot(cmd_r.chan);
					end else begin
						pulldown_en_r <= sfmdc_pkg::CH_RST;
					end
				end
				sfmdc_pkg::SFMDC_RES: begin
					meas_source_current_r <= one_hot(cmd_r.chan);
					meas_sink_current_r <= one_hot(cmd_r.chan);
					analog_meas_oe_r <= 1'b1;
					offset_cal_r <= cmd_r.offset_cal_select;
				end
				default: begin
				end
			endcase
		end
	end

	// ********************************************************
	// cs-fall capture
	// ********************************************************
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			resp_r <= '0;
		end else begin
			if (cs_fall && status_req) begin
				resp_r.cur_status <= cur_status_r;
			end
			if (cs_fall && resp_r.leak_pending) begin
				resp_r.battery_short_flag <= leak_sync_r[1];
				resp_r.ground_short_flag <= leak_sync_r[0];
			end
			// a new leak command in the capture cycle keeps pending set
			if (!arm_cmd && diag_start && diag_cmd.mode == sfmdc_pkg::SFMDC_LEAK) begin
				resp_r.leak_pending <= 1'b1;
			end else if (cs_fall) begin
				resp_r.leak_pending <= 1'b0;
			end
		end
	end

	// ********************************************************
	// spi shift-out on the link clock
	// ********************************************************
	// resp_r settles within four sys_clk cycles of cs fall and then
	// holds for the frame; the first sck edge must come later
	logic [sfmdc_pkg::BIT_W-1:0] bit_r;
	logic [sfmdc_pkg::WORD_W-1:0] shift_r;

	always_ff @(posedge spi_sck or negedge arst_n or posedge spi_cs_n) begin
		if (!arst_n || spi_cs_n) begin
			bit_r <= '0;
			shift_r <= '0;
			miso_r <= 1'b0;
			miso_oe_r <= 1'b0;
		end else begin
			bit_r <= bit_r + 1'b1;
			miso_oe_r <= 1'b1;
			if (bit_r == '0) begin
				miso_r <= resp_r[sfmdc_pkg::WORD_W-1];
				shift_r <= {resp_r[sfmdc_pkg::WORD_W-2:0], 1'b0};
			end else begin
				miso_r <= shift_r[sfmdc_pkg::WORD_W-1];
				shift_r <= {shift_r[sfmdc_pkg::WORD_W-2:0], 1'b0};
			end
		end
	end

endmodule

// ### sfmdc_assertions.sv
/*
 * concurrent checks on the ports of sfmdc_top, attached by bind.
 * assumes one sys_clk domain and the port types the design declares.
 */
`timescale 1ns/10ps
module sfmdc_assertions (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic soft_reset,
	input wire logic [sfmdc_pkg::NCH-1:0] high_drv_on,
	input wire logic [sfmdc_pkg::NCH-1:0] low_drv_on,
	input wire logic [sfmdc_pkg::NCH-1:0] clear_req,
	input wire logic [sfmdc_pkg::NFEN-1:0] fire_enable_pin,
	input wire logic mos_test,
	input wire logic [sfmdc_pkg::NCH*sfmdc_pkg::FT_W-1:0] fire_time_r,
	input wire logic offset_comp_r,
	input wire logic [sfmdc_pkg::NFEN-1:0] fire_enable_function_r,
	input wire logic [sfmdc_pkg::NCH-1:0] drive_allow_r,
	input wire logic [sfmdc_pkg::NCH-1:0] meas_source_current_r,
	input wire logic [sfmdc_pkg::NCH-1:0] meas_sink_current_r,
	input wire logic analog_meas_oe_r
);
	// ********************************************************
	// helpers and checks
	// ********************************************************
	logic [7:0] win;
	logic [9:0] gap_r;
	logic seen_r;
	logic [9:0] run_r;
	assign win = high_drv_on & low_drv_on;
	// first strobe has no predecessor, so seen_r masks it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_r <= 10'h000;
			seen_r <= 1'b0;
		end else if (offset_comp_r) begin
			gap_r <= 10'h000;
			seen_r <= 1'b1;
		end else begin
			gap_r <= gap_r + 10'h001;
		end
	end
	// raw high run of pin 0, saturates so it never wraps
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_r <= 10'h000;
		end else if (!fire_enable_pin[0]) begin
			run_r <= 10'h000;
		end else if (run_r != 10'h3ff) begin
			run_r <= run_r + 10'h001;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_gate_off;
		(fire_enable_function_r == 4'h0 && !mos_test) [*3];
	endsequence
	a_no_count_idle: assert property (win == 8'h00 && !soft_reset &&
		clear_req == 8'h00 |=> $stable(fire_time_r))
		else $error("counter moved outside window");
	a_count_step: assert property ($changed(fire_time_r[6:0]) &&
		!$past(soft_reset) && !$past(clear_req[0]) |->
		fire_time_r[6:0] == $past(fire_time_r[6:0]) + 7'h01 && $past(win[0]))
		else $error("counter step wrong");
	a_sat_hold: assert property (fire_time_r[6:0] == 7'h7f &&
		!soft_reset && !clear_req[0] |=> fire_time_r[6:0] == 7'h7f)
		else $error("saturated counter left full scale");
	a_soft_clear: assert property (soft_reset |=> fire_time_r == '0)
		else $error("soft reset left a count");
	a_fire_no_clear: assert property (clear_req[0] && win[0] &&
		!soft_reset && fire_time_r[6:0] != 7'h00 |=> fire_time_r[6:0] != 7'h00)
		else $error("clear took effect while firing");
	a_comp_period: assert property (offset_comp_r && seen_r |->
		gap_r == 10'h27f ##1 !offset_comp_r)
		else $error("compensation strobe spacing wrong");
	a_gate_off: assert property (s_gate_off |-> drive_allow_r == 8'h00)
		else $error("driver allowed without fire enable");
	a_pair_gate: assert property ($past(fire_enable_function_r[3]) &&
		fire_enable_function_r[3] |-> drive_allow_r[7:6] == 2'b11)
		else $error("last pair not enabled");
	a_res_route: assert property (analog_meas_oe_r |->
		$onehot(meas_source_current_r) &&
		meas_sink_current_r == meas_source_current_r)
		else $error("measurement currents misrouted");
	a_src_idle: assert property (!analog_meas_oe_r |->
		meas_source_current_r == 8'h00)
		else $error("source current without measurement");
	a_fen_filter: assert property ($rose(fire_enable_function_r[0]) |->
		run_r >= 10'h258)
		else $error("fire enable qualified too early");
endmodule

// ### sfmdc_host.sv
/*
 * host model on the spi side: frames of 16 clocks, msb first.
 * assumes miso changes on the rising sck edge; sck idles low.
 */
`timescale 1ns/10ps
module sfmdc_host (
	output logic spi_sck,
	output logic spi_cs_n,
	input wire logic miso_r,
	input wire logic miso_oe_r
);
	// ********************************************************
	// frame driver
	// ********************************************************
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
	end
	// undriven miso reads as unknown so a missing enable never matches
	task automatic xfer(output logic [15:0] w);
		spi_cs_n = 1'b0;
		#200;
		for (int i = 15; i >= 0; i--) begin
			spi_sck = 1'b1;
			#80;
			w[i] = miso_oe_r ? miso_r : 1'bx;
			spi_sck = 1'b0;
			#80;
		end
		spi_cs_n = 1'b1;
		#400;
	endtask
endmodule

// ### sfmdc_tb.sv
/*
 * self-checking bench for sfmdc_top with the host model on spi.
 * assumes 50 MHz sys_clk and a short hold unit for the fen timers.
 */
`timescale 1ns/10ps
module tb;
	// ********************************************************
	// bench
	// ********************************************************
	logic sys_clk, arst_n, soft_reset, mos_test, arm_cmd, diag_start;
	logic diag_stop, status_req, battery_leak_comparator;
	logic ground_leak_comparator, spi_sck, spi_cs_n;
	logic offset_comp_r, analog_meas_oe_r, offset_cal_r, miso_r, miso_oe_r;
	logic [7:0] measure_current_threshold, high_drv_on, low_drv_on;
	logic [7:0] clear_req, hold_code, cur_status_r, drive_allow_r;
	logic [7:0] pulldown_en_r, bias_high_r, bias_low_r;
	logic [7:0] meas_source_current_r, meas_sink_current_r;
	logic [3:0] fire_enable_pin, fire_enable_function_r;
	logic [55:0] fire_time_r;
	logic [15:0] w;
	sfmdc_pkg::sfmdc_cmd_s diag_cmd;
	sfmdc_pkg::sfmdc_resp_s resp_r;
	int err_total = 0;
	int n_checks = 0;
	int hc;
	sfmdc_top #(.HOLD_UNIT(20)) sfmdc_top_inst (.sys_clk, .arst_n,
		.soft_reset, .measure_current_threshold, .high_drv_on, .low_drv_on,
		.clear_req, .fire_enable_pin, .hold_code, .mos_test, .arm_cmd,
		.diag_start, .diag_stop, .diag_cmd, .status_req,
		.battery_leak_comparator, .ground_leak_comparator, .spi_sck,
		.spi_cs_n, .fire_time_r, .cur_status_r, .offset_comp_r,
		.fire_enable_function_r, .drive_allow_r, .pulldown_en_r,
		.bias_high_r, .bias_low_r, .meas_source_current_r,
		.meas_sink_current_r, .analog_meas_oe_r, .offset_cal_r, .resp_r,
		.miso_r, .miso_oe_r);
	sfmdc_host sfmdc_host_inst (.spi_sck, .spi_cs_n, .miso_r, .miso_oe_r);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic chk(input logic [55:0] got, input logic [55:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [15:0] m, input logic [15:0] exp);
		n_checks++;
		if ((w & m) !== exp) begin
			err_total++;
			$display("[FAIL] %0t spi word %h expected %h", $time, w, exp);
		end
	endtask
	// waits for channel 0 to leave a value; bounded by 3000 cycles
	task automatic wait_ft(input logic [6:0] v);
		for (int n = 0; n < 3000 && fire_time_r[6:0] === v; n++) cyc(1);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#(50000 * 20);
		err_total++;
		end_sim();
	end
	initial begin
		{arst_n, soft_reset, mos_test, arm_cmd, diag_start, diag_stop} = '0;
		{status_req, battery_leak_comparator, ground_leak_comparator} = '0;
		{clear_req, high_drv_on, low_drv_on, fire_enable_pin} = '0;
		measure_current_threshold = 8'h0d;
		hold_code = 8'he4;
		diag_cmd = '0;
		repeat (2) @(posedge sys_clk);
		#2 arst_n = 1'b1;
		cyc(2);
		high_drv_on = 8'h0b;
		low_drv_on = 8'h0b;
		wait_ft(7'h00);
		cyc(2505);
		chk(fire_time_r, 56'h0600003);
		clear_req = 8'h01;
		cyc(1);
		clear_req = 8'h00;
		cyc(2);
		chk(fire_time_r[6:0], 7'h03);
		{high_drv_on, low_drv_on} = '0;
		cyc(2500);
		chk(fire_time_r, 56'h0600003);
		{high_drv_on, low_drv_on} = {8'h0b, 8'h0b};
		wait_ft(7'h03);
		chk(fire_time_r, 56'h0800004);
		{high_drv_on, low_drv_on} = '0;
		cyc(3);
		clear_req = 8'h01;
		cyc(1);
		clear_req = 8'h00;
		cyc(3);
		chk(fire_time_r, 56'h0800000);
		soft_reset = 1'b1;
		cyc(1);
		soft_reset = 1'b0;
		cyc(2);
		chk(fire_time_r, 56'h0);
		measure_current_threshold = 8'ha5;
		cyc(2600);
		chk(cur_status_r, 8'ha5);
		status_req = 1'b1;
		sfmdc_host_inst.xfer(w);
		status_req = 1'b0;
		chk_word(16'hff00, 16'ha500);
		for (int f = 0; f < 4; f++) begin
			hc = (f == 3) ? 80 : 20 * f;
			fire_enable_pin[f] = 1'b1;
			cyc(400);
			fire_enable_pin[f] = 1'b0;
			cyc(10);
			chk(fire_enable_function_r, 4'h0);
			fire_enable_pin[f] = 1'b1;
			cyc(700);
			chk(fire_enable_function_r, 4'h1 << f);
			chk(drive_allow_r, 8'h03 << (2 * f));
			fire_enable_pin[f] = 1'b0;
			cyc(hc);
			chk(fire_enable_function_r, 4'h1 << f);
			cyc(10);
			chk(fire_enable_function_r, 4'h0);
		end
		// a second rise must reload the full hold, not keep the remainder
		fire_enable_pin[2] = 1'b1;
		cyc(700);
		fire_enable_pin[2] = 1'b0;
		cyc(20);
		fire_enable_pin[2] = 1'b1;
		cyc(700);
		fire_enable_pin[2] = 1'b0;
		cyc(40);
		chk(fire_enable_function_r, 4'h4);
		cyc(10);
		chk(fire_enable_function_r, 4'h0);
		mos_test = 1'b1;
		cyc(4);
		chk(drive_allow_r, 8'hff);
		mos_test = 1'b0;
		diag_cmd = '{sfmdc_pkg::SFMDC_IDLE, 3'h0, 1'b0, 1'b1, 1'b0};
		diag_stop = 1'b1;
		cyc(1);
		diag_stop = 1'b0;
		cyc(3);
		chk(pulldown_en_r, 8'hff);
		battery_leak_comparator = 1'b1;
		for (int k = 0; k < 4; k++) begin
			diag_cmd = '{sfmdc_pkg::SFMDC_LEAK, 3'h2, k[0], k[1], 1'b0};
			diag_start = 1'b1;
			cyc(1);
			diag_start = 1'b0;
			cyc(3);
			chk(bias_high_r, k[0] ? 8'h00 : 8'h04);
			chk(bias_low_r, k[0] ? 8'h04 : 8'h00);
			chk(pulldown_en_r, k[1] ? 8'hfb : 8'h00);
		end
		sfmdc_host_inst.xfer(w);
		chk_word(16'h00c0, 16'h0080);
		{battery_leak_comparator, ground_leak_comparator} = 2'b01;
		diag_cmd = '{sfmdc_pkg::SFMDC_LEAK, 3'h2, 1'b1, 1'b0, 1'b0};
		diag_start = 1'b1;
		cyc(1);
		diag_start = 1'b0;
		cyc(3);
		sfmdc_host_inst.xfer(w);
		chk_word(16'h00c0, 16'h0040);
		arm_cmd = 1'b1;
		cyc(1);
		arm_cmd = 1'b0;
		cyc(3);
		chk(bias_low_r, 8'h00);
		for (int c = 0; c < 2; c++) begin
			diag_cmd = '{sfmdc_pkg::SFMDC_RES, 3'h5, 1'b0, 1'b0, c[0]};
			diag_start = 1'b1;
			cyc(1);
			diag_start = 1'b0;
			cyc(3);
			chk({meas_source_current_r, meas_sink_current_r}, 16'h2020);
			chk({analog_meas_oe_r, offset_cal_r}, {1'b1, c[0]});
			diag_stop = 1'b1;
			cyc(1);
			diag_stop = 1'b0;
			cyc(3);
			chk({analog_meas_oe_r, meas_source_current_r}, 9'h0);
		end
		end_sim();
	end
endmodule
bind sfmdc_top sfmdc_assertions sfmdc_assertions_inst (.sys_clk, .arst_n,
	.soft_reset, .high_drv_on, .low_drv_on, .clear_req, .fire_enable_pin,
	.mos_test, .fire_time_r, .offset_comp_r, .fire_enable_function_r,
	.drive_allow_r, .meas_source_current_r, .meas_sink_current_r,
	.analog_meas_oe_r);
